// ===== inc/lsf_pkg.sv
// Package for the load switch fault controller: modes, timing constants, carriers.
// Assumes a single 20 MHz system clock; all intervals counted from it.
package lsf_pkg;

  // Overcurrent response options
  typedef enum logic [1:0] {
    LSF_AUTORETRY  = 2'b00,
    LSF_LATCHOFF   = 2'b01,
    LSF_CONTINUOUS = 2'b10
  } lsf_mode_t;

  // Fault sequencer states
  typedef enum logic [1:0] {
    LSF_IDLE  = 2'b00,
    LSF_BLANK = 2'b01,
    LSF_RETRY = 2'b10,
    LSF_LATCH = 2'b11
  } lsf_state_t;

  // Synchronised comparator indications
  typedef struct packed {
    logic overCurrent;
    logic reverseCurrent;
    logic overTemp;
    logic limitSetShort;
  } lsf_ind_t;

  localparam int LSF_IND_W       = 4;
  localparam int LSF_SYNC_STAGES = 2;

  // Timing
  localparam int    LSF_CLK_HZ        = 20000000;
  localparam real   LSF_BLANK_MS      = 16.3;
  localparam int    LSF_RETRY_RATIO   = 32;
  // Oscillator tick: one cycle per microsecond
  localparam int    LSF_TICK_US       = 1;
  localparam int    LSF_TICK_CYCLES   = LSF_CLK_HZ / 1000000 * LSF_TICK_US;
  // Shortest-time rounding: blanking in ticks rounded down
  localparam int    LSF_BLANK_TICKS   = int'($floor(LSF_BLANK_MS * 1000.0 / LSF_TICK_US));
  localparam int    LSF_RETRY_TICKS   = LSF_BLANK_TICKS * LSF_RETRY_RATIO;
  localparam int    LSF_CNT_W         = 20;
  localparam int    LSF_TICK_W        = 8;

  // Reset values
  localparam logic  LSF_RST_SWITCH    = 1'b0;
  localparam logic  LSF_RST_FLAG_OE   = 1'b0;

endpackage : lsf_pkg

// ===== rtl/lsf_fault_ctrl.sv
// Fault controller of a current-limit load switch: switch enable and fault flag.
// Assumes synchronous switch request; comparators are asynchronous; nrst is power-up.
//
// Notes on behaviour
// [RULE_01] Active-high variant: switch closed while request high, open while low.
// [RULE_02] Active-low variant: switch closed while request low, open while high.
// [RULE_03] Overcurrent lasting the blanking interval flags and applies the chosen response.
// [RULE_04] Autoretry: blanking timer starts on overcurrent; flag if it persists.
// [RULE_05] Overcurrent ending early clears the timer, no flag, switch unchanged.
// [RULE_06] Autoretry: retry interval starts at blanking expiry, switch held open.
// [RULE_07] Retry end recloses switch; repeat cycle if overcurrent persists.
// [RULE_08] Flag stays asserted through repeated autoretry cycles.
// [RULE_09] Latchoff: flag asserts when overcurrent outlasts blanking.
// [RULE_10] Latchoff: switch opens after blanking and stays open, no retry.
// [RULE_11] Request toggle or power cycle releases the latch.
// [RULE_12] Continuous: switch stays on; flag after blanking, cleared with overload.
// [RULE_13] Reverse current opens switch and flags at once, no blanking.
// [RULE_14] Reverse current clearing recloses switch and releases flag.
// [RULE_15] Flag also low during thermal shutdown or grounded limit-set pin.
// [RULE_16] Retry interval is exactly 32 blanking intervals from one oscillator.
// [RULE_17] Over-temperature opens switch and flags at once; recloses when clear.
// [RULE_18] Intervals are oscillator counters; response mode is a build parameter.
// [RULE_19] Comparator indications synchronised before the fault sequencer uses them.
module lsf_fault_ctrl #(
  parameter lsf_pkg::lsf_mode_t MODE        = lsf_pkg::LSF_AUTORETRY,
  parameter bit                 ACTIVE_LOW  = 1'b0,
  parameter int                 TICK_DIV    = lsf_pkg::LSF_TICK_CYCLES,
  parameter int                 BLANK_TICKS = lsf_pkg::LSF_BLANK_TICKS
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Switch request, polarity per variant
  input  wire logic switchReq,
  // Comparator indications, asynchronous
  input  wire logic overCurrentIn,
  input  wire logic reverseCurrentIn,
  input  wire logic overTempIn,
  input  wire logic limitSetShortIn,
  // Pass switch and open-drain flag
  output logic      switchEn,
  output logic      flagOut,
  output logic      flagOe
);

  localparam int CW = lsf_pkg::LSF_CNT_W;
  // Retry derived from blanking so the ratio cannot drift
  localparam int RETRY_TICKS = BLANK_TICKS * lsf_pkg::LSF_RETRY_RATIO; // [RULE_16]

  lsf_pkg::lsf_ind_t   ind;
  lsf_pkg::lsf_state_t state;
  lsf_pkg::lsf_state_t next_state;
  logic [CW-1:0]       count;
  logic                tick;
  logic                reqOn;
  logic                reqPrev;
  logic                reqToggle;
  logic                hardFault;
  logic                blankDone;
  logic                retryDone;
  logic                ocFlag;
  logic                retried;
  logic                next_switchEn;
  logic                next_flag;

  // Comparators are analog, so their edges are unrelated to mclk
  lsf_sync #(
    .WIDTH  (lsf_pkg::LSF_IND_W),
    .STAGES (lsf_pkg::LSF_SYNC_STAGES)
  ) u_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .asyncIn ({overCurrentIn, reverseCurrentIn, overTempIn, limitSetShortIn}),
    .syncOut (ind)
  ); // [RULE_19]

  lsf_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .mclk (mclk),
    .nrst (nrst),
    .tick (tick)
  ); // [RULE_18]

  // Request polarity
  assign reqOn = ACTIVE_LOW ? !switchReq : switchReq; // [RULE_01] [RULE_02]

  // Request edge for latch release; power cycle is nrst
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reqPrev <= 1'b0;
    end else begin
      reqPrev <= reqOn;
    end
  end
  assign reqToggle = reqOn != reqPrev; // [RULE_11]

  // Immediate faults bypass blanking
  assign hardFault = ind.reverseCurrent || ind.overTemp; // [RULE_13] [RULE_17]

  assign blankDone = tick && (count == CW'(BLANK_TICKS - 1)); // [RULE_04]
  assign retryDone = tick && (count == CW'(RETRY_TICKS - 1)); // [RULE_06]

  // Fault sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      lsf_pkg::LSF_IDLE: begin
        if (ind.overCurrent && reqOn && !hardFault) begin
          next_state = lsf_pkg::LSF_BLANK; // [RULE_04]
        end
      end
      lsf_pkg::LSF_BLANK: begin
        if (!ind.overCurrent || !reqOn) begin
          next_state = lsf_pkg::LSF_IDLE; // [RULE_05]
        end else if (blankDone) begin
          unique case (MODE)
            lsf_pkg::LSF_AUTORETRY: next_state = lsf_pkg::LSF_RETRY; // [RULE_03] [RULE_06]
            lsf_pkg::LSF_LATCHOFF:  next_state = lsf_pkg::LSF_LATCH; // [RULE_10]
            default:                next_state = lsf_pkg::LSF_LATCH; // [RULE_12]
          endcase
        end
      end
      lsf_pkg::LSF_RETRY: begin
        if (!reqOn) begin
          next_state = lsf_pkg::LSF_IDLE;
        end else if (retryDone) begin
          // Retry: back to blanking if still overloaded, else run
          next_state = ind.overCurrent ? lsf_pkg::LSF_BLANK : lsf_pkg::LSF_IDLE; // [RULE_07]
        end
      end
      lsf_pkg::LSF_LATCH: begin
        if (MODE == lsf_pkg::LSF_CONTINUOUS) begin
          if (!ind.overCurrent || !reqOn) begin
            next_state = lsf_pkg::LSF_IDLE; // [RULE_12]
          end
        end else if (reqToggle) begin
          next_state = lsf_pkg::LSF_IDLE; // [RULE_11]
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= lsf_pkg::LSF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Marks a blanking entered from retry; a strap-short flag must not make it sticky
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      retried <= 1'b0;
    end else begin
      retried <= (state == lsf_pkg::LSF_RETRY)
                 || (state == lsf_pkg::LSF_BLANK && retried); // [RULE_08]
    end
  end

  // Interval counter, cleared on every state change
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count <= '0;
    end else if (next_state != state) begin
      count <= '0; // [RULE_05]
    end else if (tick && (state == lsf_pkg::LSF_BLANK || state == lsf_pkg::LSF_RETRY)) begin
      count <= count + 1'b1; // [RULE_18]
    end
  end

  // Overcurrent part of the flag
  always_comb begin
    unique case (state)
      lsf_pkg::LSF_RETRY: ocFlag = 1'b1; // [RULE_08]
      lsf_pkg::LSF_LATCH: ocFlag = 1'b1; // [RULE_09] [RULE_12]
      // Repeat blanking after a retry keeps the flag high
      lsf_pkg::LSF_BLANK: ocFlag = retried && (MODE == lsf_pkg::LSF_AUTORETRY); // [RULE_08]
      default:            ocFlag = 1'b0;
    endcase
  end

  always_comb begin
    next_flag = ocFlag || hardFault || ind.limitSetShort; // [RULE_15] [RULE_13] [RULE_17]
    next_switchEn = reqOn && !hardFault; // [RULE_14] [RULE_17]
    if (state == lsf_pkg::LSF_RETRY) begin
      next_switchEn = 1'b0; // [RULE_06]
    end
    if (state == lsf_pkg::LSF_LATCH && MODE != lsf_pkg::LSF_CONTINUOUS) begin
      next_switchEn = 1'b0; // [RULE_10]
    end
  end

  // Registered outputs; flag pin driven low only, never high
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      switchEn <= lsf_pkg::LSF_RST_SWITCH;
      flagOe   <= lsf_pkg::LSF_RST_FLAG_OE;
      flagOut  <= 1'b0;
    end else begin
      switchEn <= next_switchEn; // [RULE_01] [RULE_02]
      flagOe   <= next_flag; // [RULE_03]
      flagOut  <= 1'b0;
    end
  end

endmodule // lsf_fault_ctrl

// ===== rtl/lsf_sync.sv
// Two-stage synchroniser bank for the comparator indications.
// Assumes inputs may change at any time relative to mclk.
module lsf_sync #(
  parameter int WIDTH  = 4,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage [STAGES];

  // First stage feeds only the next stage
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_stage
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          stage[i] <= '0;
        end else begin
          stage[i] <= (i == 0) ? asyncIn : stage[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  assign syncOut = stage[STAGES-1];

endmodule // lsf_sync

// ===== rtl/lsf_tick.sv
// Oscillator divider: one-cycle enable pulse every DIV cycles of mclk.
// Assumes mclk runs continuously; the pulse paces the single interval counter used for blanking and retry.
module lsf_tick #(
  parameter int DIV = 20
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Enable pulse
  output logic      tick
);

  logic [lsf_pkg::LSF_TICK_W-1:0] count;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == lsf_pkg::LSF_TICK_W'(DIV - 1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // lsf_tick

// ===== test/lsf_fault_ctrl_asserts.sv
// Checker for the fault controller ports, every build and request polarity.
// Assumes one indication at a time and nrst as the only reset.
module lsf_fault_ctrl_asserts #(
  parameter int TICK_DIV    = 2,
  parameter int BLANK_TICKS = 4,
  parameter bit ACTIVE_LOW  = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Request and indications
  input wire logic switchReq,
  input wire logic overCurrentIn,
  input wire logic reverseCurrentIn,
  input wire logic overTempIn,
  input wire logic limitSetShortIn,
  // Outputs
  input wire logic switchEn,
  input wire logic flagOut,
  input wire logic flagOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_retryEntry;
    $fell(switchEn) && flagOe && overCurrentIn && (switchReq != ACTIVE_LOW);
  endsequence
  sequence s_retryHold;
    (!switchEn && flagOe) [*8];
  endsequence
  property p_reqOff;
    (switchReq == ACTIVE_LOW) |=> !switchEn;
  endproperty
  property p_pinLow;
    flagOut == 1'b0;
  endproperty
  property p_revTrip;
    reverseCurrentIn [*4] |-> flagOe && !switchEn;
  endproperty
  property p_tempTrip;
    overTempIn [*4] |-> flagOe && !switchEn;
  endproperty
  property p_limitShort;
    limitSetShortIn [*4] |-> flagOe;
  endproperty
  // Only a long overcurrent, a hard fault or a limit-set short may raise the flag
  property p_flagCause;
    $rose(flagOe) |-> $past(overCurrentIn, 6) || $past(reverseCurrentIn, 2)
      || $past(overTempIn, 2) || $past(limitSetShortIn, 2);
  endproperty
  property p_retryHold;
    s_retryEntry |=> s_retryHold;
  endproperty
  property p_syncDelay;
    $rose(reverseCurrentIn) && switchEn && (switchReq != ACTIVE_LOW) |=> switchEn;
  endproperty
  a_reqOff: assert property (p_reqOff) else $error("switch on with request off");
  a_pinLow: assert property (p_pinLow) else $error("flag pin driven high");
  a_revTrip: assert property (p_revTrip) else $error("reverse fault not tripped");
  a_tempTrip: assert property (p_tempTrip) else $error("thermal fault not tripped");
  a_limitShort: assert property (p_limitShort) else $error("limit short not flagged");
  a_flagCause: assert property (p_flagCause) else $error("flag without cause");
  a_retryHold: assert property (p_retryHold) else $error("retry hold broken");
  a_syncDelay: assert property (p_syncDelay) else $error("indication not synced");
endmodule // lsf_fault_ctrl_asserts

// ===== test/lsf_host_model.sv
// Host side of the open-drain fault pin: pull-up and reader.
// Assumes flagOe high means the device pulls the pin low.
module lsf_host_model (
  // Device pin drive
  input  wire logic flagOut,
  input  wire logic flagOe,
  // Fault as the host sees it
  output logic      faultSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pinLevel;
  // Pull-up wins while the device lets go
  assign pinLevel  = flagOe ? flagOut : 1'b1;
  assign faultSeen = !pinLevel;
endmodule // lsf_host_model

// ===== test/test_load_switch_fault_controller.sv
// Testbench: all three responses and both request polarities, short intervals, host on flag.
// Assumes intervals scale with TICK_DIV and BLANK_TICKS.
module test_load_switch_fault_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;
  localparam int BLK = 4;
  localparam int BC  = DIV * BLK;
  localparam int RC  = BC * 32;
  logic              mclk, nrst, switchReq, switchEn, flagOut, flagOe, faultSeen;
  logic              reqLow, swLatch, oeLatch, swCont, oeCont, swLow, oeLow;
  lsf_pkg::lsf_ind_t ind;
  int                failures, comparisons, seed, n;
  lsf_fault_ctrl #(.TICK_DIV(DIV), .BLANK_TICKS(BLK)) dut_u (.mclk(mclk), .nrst(nrst),
    .switchReq(switchReq), .overCurrentIn(ind.overCurrent),
    .reverseCurrentIn(ind.reverseCurrent), .overTempIn(ind.overTemp),
    .limitSetShortIn(ind.limitSetShort), .switchEn(switchEn), .flagOut(flagOut),
    .flagOe(flagOe));
  lsf_host_model host_u (.flagOut(flagOut), .flagOe(flagOe), .faultSeen(faultSeen));
  lsf_fault_ctrl #(.MODE(lsf_pkg::LSF_LATCHOFF), .TICK_DIV(DIV), .BLANK_TICKS(BLK)) latch_u (
    .mclk(mclk), .nrst(nrst), .switchReq(switchReq), .overCurrentIn(ind.overCurrent),
    .reverseCurrentIn(ind.reverseCurrent), .overTempIn(ind.overTemp),
    .limitSetShortIn(ind.limitSetShort), .switchEn(swLatch), .flagOut(), .flagOe(oeLatch));
  lsf_fault_ctrl #(.MODE(lsf_pkg::LSF_CONTINUOUS), .TICK_DIV(DIV), .BLANK_TICKS(BLK)) cont_u (
    .mclk(mclk), .nrst(nrst), .switchReq(switchReq), .overCurrentIn(ind.overCurrent),
    .reverseCurrentIn(ind.reverseCurrent), .overTempIn(ind.overTemp),
    .limitSetShortIn(ind.limitSetShort), .switchEn(swCont), .flagOut(), .flagOe(oeCont));
  lsf_fault_ctrl #(.ACTIVE_LOW(1'b1), .TICK_DIV(DIV), .BLANK_TICKS(BLK)) low_u (
    .mclk(mclk), .nrst(nrst), .switchReq(reqLow), .overCurrentIn(ind.overCurrent),
    .reverseCurrentIn(ind.reverseCurrent), .overTempIn(ind.overTemp),
    .limitSetShortIn(ind.limitSetShort), .switchEn(swLow), .flagOut(), .flagOe(oeLow));
  // Inverted request follows the bench's falling-edge drive
  assign reqLow = !switchReq;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // Tick phase is free, so spans carry one tick of slack
  function automatic logic [31:0] inWin(input int v, input int lo, input int hi);
    return 32'(v >= lo && v <= hi);
  endfunction
  task automatic waitSw(input logic v, output int k);
    k = 0;
    while (switchEn !== v && k < 1000) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(50 * 6000);
    failures++;
    print_verdict();
  end
  initial begin
    seed = 52907;
    nrst = 1'b0;
    switchReq = 1'b0;
    ind = '0;
    cyc(6);
    check(switchEn, 0);
    nrst = 1'b1;
    for (int i = 0; i < 24; i++) begin
      switchReq = 1'($random(seed));
      cyc(2);
      check(switchEn, switchReq);
      check(swLow, switchReq);
    end
    switchReq = 1'b1;
    cyc(2);
    for (int i = 0; i < 6; i++) begin
      ind.overCurrent = 1'b1;
      cyc(1 + ($unsigned($random(seed)) % 4));
      ind.overCurrent = 1'b0;
      cyc(BC + 4);
      check({switchEn, faultSeen}, 2'b10);
    end
    ind.overCurrent = 1'b1;
    waitSw(1'b0, n);
    check(inWin(n, BC + 1, BC + 6), 1);
    check(faultSeen, 1);
    check({swLow, oeLow}, 2'b01);
    check({swLatch, oeLatch}, 2'b01);
    check({swCont, oeCont}, 2'b11);
    waitSw(1'b1, n);
    check(inWin(n, RC - 3, RC + 3), 1);
    check(faultSeen, 1);
    check({swLatch, oeLatch, swCont, oeCont}, 4'b0111);
    waitSw(1'b0, n);
    check(inWin(n, BC - 2, BC + 4), 1);
    ind.overCurrent = 1'b0;
    waitSw(1'b1, n);
    cyc(4);
    check({switchEn, faultSeen}, 2'b10);
    check({swLatch, oeLatch, swCont, oeCont}, 4'b0110);
    for (int i = 0; i < 3; i++) begin
      ind = lsf_pkg::lsf_ind_t'(4'h4 >> i);
      cyc(4);
      check(faultSeen, 1);
      if (i < 2) check(switchEn, 0);
      ind = '0;
      cyc(4);
      check({switchEn, faultSeen}, 2'b10);
    end
    check({swLatch, oeLatch}, 2'b01);
    switchReq = 1'b0;
    cyc(2);
    check({swLatch, oeLatch}, 2'b00);
    switchReq = 1'b1;
    cyc(2);
    check(swLatch, 1);
    nrst = 1'b0;
    cyc(2);
    check({switchEn, faultSeen}, 2'b00);
    nrst = 1'b1;
    cyc(3);
    check(switchEn, 1);
    check({swLatch, swCont, swLow}, 3'b111);
    print_verdict();
  end
endmodule // test_load_switch_fault_controller
bind lsf_fault_ctrl lsf_fault_ctrl_asserts #(.TICK_DIV(TICK_DIV), .BLANK_TICKS(BLANK_TICKS),
  .ACTIVE_LOW(ACTIVE_LOW))
  chk_u (.mclk(mclk), .nrst(nrst), .switchReq(switchReq), .overCurrentIn(overCurrentIn),
  .reverseCurrentIn(reverseCurrentIn), .overTempIn(overTempIn),
  .limitSetShortIn(limitSetShortIn), .switchEn(switchEn), .flagOut(flagOut), .flagOe(flagOe));
